// [bench/sjt_ctl_model.sv]
// behavioural board-level scan controller driving the test clock, select and serial input
// assumes: tdo_i/tdo_oe_i come straight from the port; the bench calls its tasks in order
`timescale 1ns/10ps
module sjt_ctl_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);

    ////////////////////////////////////////////////////////////////////////////
    // test clock stands low between steps; select and data idle at the pulled-up level
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // one test clock period of 48 ns; signals change while the clock is low
    // and are held across the rising edge; the output is read just before it
    task automatic step(input logic tms, input logic tdi, output logic o, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #24;
        o = tdo_oe_i ? tdo_i : ~tdo_i; // no keeper: a released line reads as garbage
        oe = tdo_oe_i;
        tck_o = 1'b1;
        #24;
        tck_o = 1'b0;
    endtask

    // from idle: walk to the shift state, shift n bits, leave through update to idle;
    // oe_ok drops if the output was not driven while shifting or still driven after
    task automatic scan(input bit ir, input int n, input logic [79:0] din,
                        output logic [79:0] dout, output bit oe_ok);
        logic o;
        logic oe;
        step(1'b1, 1'b1, o, oe);
        if (ir) begin
            step(1'b1, 1'b1, o, oe);
        end
        step(1'b0, 1'b1, o, oe);
        step(1'b0, 1'b1, o, oe);
        oe_ok = 1'b1;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o, oe);
            dout[i] = o;
            if (oe !== 1'b1) begin
                oe_ok = 1'b0;
            end
        end
        step(1'b1, 1'b1, o, oe);
        if (oe !== 1'b0) begin
            oe_ok = 1'b0;
        end
        step(1'b0, 1'b1, o, oe);
    endtask

endmodule

// [bench/sram_jtag_test_access_port_test.sv]
// self-checking bench for the memory test access port
// assumes: the controller model owns the test clock; ring and reset change on falling ref_clk
`timescale 1ns/10ps
module sram_jtag_test_access_port_test;
    import sjt_pkg::*;

    logic ref_clk_i;
    logic rstn_i;
    logic tck;
    logic tms;
    logic tdi;
    logic [BSR_W-1:0] ring;
    logic tdo;
    logic tdo_oe;
    logic mem_hiz;
    int n_errors = 0;
    int checks = 0;
    integer seed = 32'h4ead;

    sjt_tap_top sjt_tap_top_inst (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .mem_hiz_o(mem_hiz)
    );

    sjt_ctl_model sjt_ctl_model_inst (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // memory clock at 125 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // serial output expected for a chain of len bits captured as cap, fed with din
    function automatic logic [79:0] exp_out(int len, logic [79:0] cap, logic [79:0] din);
        logic [79:0] r;
        for (int i = 0; i < 80; i++) begin
            if (i < len) begin
                r[i] = cap[i];
            end else begin
                r[i] = din[i - len];
            end
        end
        return r;
    endfunction

    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // idle steps; three of them let the float request cross into the memory clock
    task automatic idle(input int n);
        logic o;
        logic oe;
        repeat (n) sjt_ctl_model_inst.step(1'b0, 1'b1, o, oe);
    endtask

    // load an instruction and check the fixed capture pattern and output enable
    task automatic load_ir(input logic [2:0] code);
        logic [79:0] d;
        bit ok;
        sjt_ctl_model_inst.scan(1'b1, IR_W, {77'h0, code}, d, ok);
        chk(d[2:0], {IR_CAPTURE_HI, IR_CAPTURE_LO}, "ir capture");
        chk(ok, 1'b1, "tdo enable ir");
        idle(3);
    endtask

    // capture and shift 80 bits; the chain length and contents follow the code
    task automatic scan_dr(input logic [2:0] code);
        logic [79:0] din;
        logic [79:0] d;
        logic [95:0] rnd;
        bit ok;
        int len;
        logic [79:0] cap;
        rnd = {$random(seed), $random(seed), $random(seed)};
        @(negedge ref_clk_i);
        ring = rnd[BSR_W-1:0];
        idle(3);
        din = rnd[79:0] ^ 80'({$random(seed), $random(seed), $random(seed)});
        len = 1;
        cap = '0;
        if (code == INS_EXTEST || code == INS_SAMPLE_Z || code == INS_SAMPLE) begin
            len = BSR_W;
            cap = {5'h00, ring};
        end else if (code == INS_IDCODE) begin
            len = ID_W;
            cap = {48'h0, ID_VALUE};
        end
        sjt_ctl_model_inst.scan(1'b0, 80, din, d, ok);
        chk(d, exp_out(len, cap, din), "data chain");
        chk(ok, 1'b1, "tdo enable dr");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run of about 75 us
    initial begin
        #400000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial begin
        logic [2:0] code;
        logic o;
        logic oe;
        rstn_i = 1'b0;
        ring = '0;
        fork
            begin
                repeat (16) @(negedge ref_clk_i);
                rstn_i <= 1'b1;
            end
            idle(3);
        join
        repeat (3) sjt_ctl_model_inst.step(1'b1, 1'b1, o, oe);
        chk(oe, 1'b0, "tdo floats after reset");
        chk(mem_hiz, 1'b0, "memory not floated");
        idle(1);
        scan_dr(INS_IDCODE);
        // every code, then random codes, back to back
        for (int k = 0; k < 12; k++) begin
            code = (k < 8) ? 3'(k) : 3'($random(seed));
            // the sweep covers the reserved codes once; random traffic stays legal
            if (k >= 8 && (code == 3'h3 || code == 3'h5 || code == 3'h6)) begin
                code = INS_BYPASS;
            end
            load_ir(code);
            chk(mem_hiz, code == INS_EXTEST || code == INS_SAMPLE_Z, "float");
            scan_dr(code);
            idle(3);
            chk(mem_hiz, code == INS_EXTEST || code == INS_SAMPLE_Z, "update dr");
        end
        // select held high for five edges from idle returns to reset with identification
        load_ir(INS_SAMPLE_Z);
        repeat (5) sjt_ctl_model_inst.step(1'b1, 1'b1, o, oe);
        idle(4);
        chk(mem_hiz, 1'b0, "float cleared by reset");
        scan_dr(INS_IDCODE);
        // power-up reset again in mid-run while the memory outputs are floated
        load_ir(INS_EXTEST);
        chk(mem_hiz, 1'b1, "float before second reset");
        @(negedge ref_clk_i);
        rstn_i <= 1'b0;
        idle(3);
        chk(mem_hiz, 1'b0, "float cleared by power-up reset");
        @(negedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (3) sjt_ctl_model_inst.step(1'b1, 1'b1, o, oe);
        chk(oe, 1'b0, "tdo floats after second reset");
        idle(1);
        scan_dr(INS_IDCODE);
        conclude();
    end

endmodule

// [rtl/sjt_pkg.sv]
// shared constants and types for the memory test access port
// assumes: imported by every design file of the port except the strobe interface; no clocks or logic here
package sjt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register sizes
    localparam int IR_W = 3;
    localparam int BSR_W = 75;
    localparam int ID_W = 32;
    localparam int SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes; codes 3, 5 and 6 are reserved
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // fixed pattern loaded into the two low instruction bits on capture
    localparam logic [1:0] IR_CAPTURE_LO = 2'h1;
    localparam logic IR_CAPTURE_HI = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // identification value fields, high to low
    localparam logic [3:0] ID_REVISION = 4'h0;
    localparam logic [4:0] ID_DEPTH = 5'h07;
    localparam logic [4:0] ID_WIDTH = 5'h03;
    localparam logic [5:0] ID_DEVICE = 6'h00;
    localparam logic [10:0] ID_VENDOR = 11'h2A5; // arbitrary value, not a real maker code
    localparam logic ID_PRESENT = 1'h1;
    localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_DEVICE,
                                        ID_VENDOR, ID_PRESENT};

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic BYP_RST = 1'h0;
    localparam logic TDO_RST = 1'h0;
    localparam logic HIZ_RST = 1'h0;

    // sixteen controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sjt_state_t;

endpackage

// [rtl/sjt_sync.sv]
// multi-bit two-stage level synchroniser with a synchronous clear
// assumes: each bit is an independent level; no word coherence across bits
`timescale 1ns/10ps
module sjt_sync
    import sjt_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = rst_n_i ? d_i : '0;
        next_q = rst_n_i ? meta : '0;
    end

    always_ff @(posedge clk_i) begin
        meta <= next_meta;
        q_o <= next_q;
    end

endmodule

// [rtl/sjt_tap_fsm.sv]
// sixteen-state test access controller, stepping on the rising test clock
// assumes: rstn_i is already synchronised to tck_i
`timescale 1ns/10ps
module sjt_tap_fsm
    import sjt_pkg::*;
(
    input wire logic tck_i,
    input wire logic rstn_i,
    input wire logic tms_i,
    sjt_tap_if.ctl tap
);

    sjt_state_t st;
    sjt_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // next state from sampled select; an idle-high select walks into reset
    always_comb begin
        next_st = st;
        case (st)
            ST_RESET: next_st = tms_i ? ST_RESET : ST_IDLE;
            ST_IDLE: next_st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_st = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_st = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_st = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_st = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_st = tms_i ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_st = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_st = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_st = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_st = tms_i ? ST_SEL_DR : ST_IDLE;
            default: next_st = ST_RESET;
        endcase
        if (!rstn_i) begin
            next_st = ST_RESET;
        end
    end

    always_ff @(posedge tck_i) begin
        st <= next_st;
    end

    // state strobes for the data path
    assign tap.test_reset = (st == ST_RESET);
    assign tap.capture_dr = (st == ST_CAP_DR);
    assign tap.shift_dr = (st == ST_SHIFT_DR);
    assign tap.update_dr = (st == ST_UPD_DR);
    assign tap.capture_ir = (st == ST_CAP_IR);
    assign tap.shift_ir = (st == ST_SHIFT_IR);
    assign tap.update_ir = (st == ST_UPD_IR);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_tms_five_reset: assert property (@(posedge tck_i) disable iff (!rstn_i)
        tms_i [*5] |=> st == ST_RESET)
        else $error("five high select edges did not reach reset");

    chk_update_ir_path: assert property (@(posedge tck_i) disable iff (!rstn_i)
        st == ST_UPD_IR |-> $past(st) == ST_EXIT1_IR || $past(st) == ST_EXIT2_IR)
        else $error("instruction update entered from a wrong state");

endmodule

// [rtl/sjt_tap_if.sv]
// state strobes passed from the controller to the scan data path
// assumes: both ends run on the test clock
`timescale 1ns/10ps
interface sjt_tap_if;
    logic test_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport ctl (output test_reset, capture_dr, shift_dr, update_dr,
                 capture_ir, shift_ir, update_ir);
    modport dp (input test_reset, capture_dr, shift_dr, update_dr,
                capture_ir, shift_ir, update_ir);
endinterface

// [rtl/sjt_tap_top.sv]
// scan test access port of a burst memory: controller, instruction,
// bypass, identification and boundary registers, serial output stage
// assumes: tck_i is a free clock from the test controller; ring_i and
// rstn_i come from the memory clock domain; pad pull-ups sit outside
`timescale 1ns/10ps

// Operation
// - Inputs sampled on rising test clock; serial outputs change on falling edge only.
// - Select steers controller on rising edge; floating select reads high.
// - Serial input enters selected register MSB; output shows its LSB.
// - Serial output driven only in shift states, high-impedance otherwise.
// - Five rising edges with select high reset controller without disturbing memory.
// - Power-up resets the port; serial output starts high-impedance.
// - Exactly one register sits in the scan path, chosen by instruction.
// - Three-bit instruction register loads IDCODE at power-up and on reset.
// - Instruction capture loads binary 01 into the two low bits.
// - BYPASS selects one-bit register, cleared to zero when it takes effect.
// - Boundary register of 75 bits captures ring, then shifts.
// - IDCODE captures a hardwired 32-bit value into the ID register.
// - Instructions shift in during shift-IR, take effect at update-IR only.
// - All-zero code acts like sample but also floats memory outputs.
// - SAMPLE Z selects boundary register and floats memory outputs.
// - Sample captures pin snapshot; update-DR loads nothing into pins.
// - No instruction drives or preloads memory pins; no internal test.
// - All-zero code selects boundary register, captures ring, floats outputs.
// - ID bit 0 is one; upper fields carry revision, depth, width, vendor.
module sjt_tap_top
    import sjt_pkg::*;
#(
    parameter logic [31:0] ID_CODE = ID_VALUE
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_W-1:0] ring_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic mem_hiz_o
);

    sjt_tap_if tap ();

    logic tck_rstn;
    logic [BSR_W-1:0] ring_sync;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] next_ir;
    logic [IR_W-1:0] next_ir_sr;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] next_bsr;
    logic [ID_W-1:0] id_sr;
    logic [ID_W-1:0] next_id_sr;
    logic byp;
    logic next_byp;
    logic hiz_tck;
    logic next_hiz_tck;
    logic next_tdo;
    logic next_tdo_oe;
    logic sel_bsr;
    logic sel_id;
    logic dr_lsb;

    ////////////////////////////////////////////////////////////////////////////
    // crossings into the test clock domain

    // power-up reset reaches the test clock through two flops
    sjt_sync #(.W(1)) u_rst_sync (
        .clk_i(tck_i),
        .rst_n_i(1'b1),
        .d_i(rstn_i),
        .q_o(tck_rstn)
    );

    // ring pins toggle at memory speed; synchronise before capture, which
    // delays the snapshot by two test clocks but never samples metastable data
    sjt_sync #(.W(BSR_W)) u_ring_sync (
        .clk_i(tck_i),
        .rst_n_i(tck_rstn),
        .d_i(ring_i),
        .q_o(ring_sync)
    );

    sjt_tap_fsm u_fsm (
        .tck_i(tck_i),
        .rstn_i(tck_rstn),
        .tms_i(tms_i),
        .tap(tap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode: one register in the path at a time
    always_comb begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        if (ir == INS_EXTEST || ir == INS_SAMPLE || ir == INS_SAMPLE_Z) begin
            sel_bsr = 1'b1;
        end else if (ir == INS_IDCODE) begin
            sel_id = 1'b1;
        end
        // bypass and the reserved codes fall through to the bypass bit
    end

    // least significant bit of whatever sits in the path
    always_comb begin
        if (tap.shift_ir) begin
            dr_lsb = ir_sr[0];
        end else if (sel_bsr) begin
            dr_lsb = bsr[0];
        end else if (sel_id) begin
            dr_lsb = id_sr[0];
        end else begin
            dr_lsb = byp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction shift and latched instruction
    always_comb begin
        next_ir_sr = ir_sr;
        next_ir = ir;
        if (tap.capture_ir) begin
            next_ir_sr = {IR_CAPTURE_HI, IR_CAPTURE_LO};
        end else if (tap.shift_ir) begin
            next_ir_sr = {tdi_i, ir_sr[IR_W-1:1]};
        end
        if (tap.update_ir) begin
            next_ir = ir_sr;
        end
        if (tap.test_reset) begin
            next_ir = INS_IDCODE;
        end
    end

    always_ff @(posedge tck_i) begin
        ir_sr <= next_ir_sr;
        ir <= next_ir;
    end

    ////////////////////////////////////////////////////////////////////////////
    // data registers; update-DR has no effect, there is no preload stage
    always_comb begin
        next_bsr = bsr;
        next_id_sr = id_sr;
        next_byp = byp;
        if (tap.capture_dr) begin
            if (sel_bsr) begin
                next_bsr = ring_sync;
            end else if (sel_id) begin
                next_id_sr = ID_CODE;
            end else begin
                next_byp = BYP_RST;
            end
        end else if (tap.shift_dr) begin
            if (sel_bsr) begin
                next_bsr = {tdi_i, bsr[BSR_W-1:1]};
            end else if (sel_id) begin
                next_id_sr = {tdi_i, id_sr[ID_W-1:1]};
            end else begin
                next_byp = tdi_i;
            end
        end
        if (tap.update_ir || tap.test_reset) begin
            next_byp = BYP_RST;
        end
    end

    always_ff @(posedge tck_i) begin
        bsr <= next_bsr;
        id_sr <= next_id_sr;
        byp <= next_byp;
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory output float request; the only effect on the memory is to
    // release its outputs, nothing is ever driven into it
    always_comb begin
        next_hiz_tck = (ir == INS_EXTEST || ir == INS_SAMPLE_Z);
        if (!tck_rstn) begin
            next_hiz_tck = HIZ_RST;
        end
    end

    always_ff @(posedge tck_i) begin
        hiz_tck <= next_hiz_tck;
    end

    // level crossing to the memory clock; a test reset only clears this
    // level, the memory keeps running undisturbed
    sjt_sync #(.W(1)) u_hiz_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rstn_i),
        .d_i(hiz_tck),
        .q_o(mem_hiz_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // serial output stage on the falling edge; enable only while shifting
    always_comb begin
        next_tdo = dr_lsb;
        next_tdo_oe = tap.shift_dr || tap.shift_ir;
        if (!tck_rstn) begin
            next_tdo = TDO_RST;
            next_tdo_oe = 1'b0;
        end
    end

    always_ff @(negedge tck_i) begin
        tdo_o <= next_tdo;
        tdo_oe_o <= next_tdo_oe;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_tdo_oe_shift: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tdo_oe_o == (tap.shift_dr || tap.shift_ir))
        else $error("serial output enable outside a shift state");

    chk_tdo_lsb_out: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tdo_oe_o |-> tdo_o == dr_lsb)
        else $error("serial output does not show the path lsb");

    chk_ir_reset_idcode: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.test_reset |=> ir == INS_IDCODE)
        else $error("instruction not IDCODE after reset state");

    chk_ir_capture_01: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_ir |=> ir_sr[1:0] == IR_CAPTURE_LO)
        else $error("instruction capture pattern wrong");

    chk_ir_update_only: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        !tap.update_ir && !tap.test_reset |=> $stable(ir))
        else $error("instruction changed outside update");

    chk_ir_update_take: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.update_ir |=> ir == $past(ir_sr))
        else $error("update did not take the shifted instruction");

    chk_bypass_clear: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_dr && !sel_bsr && !sel_id |=> byp == 1'b0)
        else $error("bypass bit not cleared on capture");

    chk_id_capture_val: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_dr && ir == INS_IDCODE |=> id_sr == ID_CODE && id_sr[0])
        else $error("identification value not captured");

    chk_bsr_shift_in: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.shift_dr && sel_bsr |=> bsr == {$past(tdi_i), $past(bsr[BSR_W-1:1])})
        else $error("boundary register did not shift from msb");

    chk_hiz_modes: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        ##1 hiz_tck == $past(ir == INS_EXTEST || ir == INS_SAMPLE_Z))
        else $error("memory float request does not follow instruction");

    chk_update_dr_noop: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.update_dr |=> $stable(bsr) && $stable(id_sr))
        else $error("update-DR altered a data register");

    ////////////////////////////////////////////////////////////////////////////
    // per-register checks written from the instruction code, not from the decode,
    // so a slip in the select logic shows up here as well
    chk_ir_capture_all: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_ir |=> ir_sr == {IR_CAPTURE_HI, IR_CAPTURE_LO})
        else $error("instruction capture high bit wrong");

    chk_ir_shift_in: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.shift_ir |=> ir_sr == {$past(tdi_i), $past(ir_sr[IR_W-1:1])})
        else $error("instruction register did not shift from msb");

    chk_tdo_ir_lsb: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.shift_ir && tdo_oe_o |-> tdo_o == ir_sr[0])
        else $error("serial output does not show the instruction lsb");

    chk_id_shift_in: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.shift_dr && ir == INS_IDCODE |=> id_sr == {$past(tdi_i), $past(id_sr[ID_W-1:1])})
        else $error("identification register did not shift from msb");

    chk_bypass_shift_in: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.shift_dr && ir == INS_BYPASS |=> byp == $past(tdi_i))
        else $error("bypass bit did not take the serial input");

    chk_bypass_update: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.update_ir |=> !byp)
        else $error("bypass bit not cleared when an instruction takes effect");

    chk_sample_snapshot: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_dr && ir == INS_SAMPLE |=> bsr == $past(ring_sync))
        else $error("sample did not capture the ring");

    chk_extest_capture: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_dr && (ir == INS_EXTEST || ir == INS_SAMPLE_Z)
        |=> bsr == $past(ring_sync))
        else $error("floating codes did not capture the ring");

    // reserved codes must leave the long registers alone and clear the bypass bit
    chk_reserved_bypass: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.capture_dr && (ir == 3'h3 || ir == 3'h5 || ir == 3'h6)
        |=> !byp && $stable(bsr) && $stable(id_sr))
        else $error("reserved code did not select the bypass bit");

    chk_hiz_tap_reset: assert property (@(posedge tck_i) disable iff (!tck_rstn)
        tap.test_reset |=> ##1 !hiz_tck)
        else $error("float request survived a controller reset");

endmodule
